/* design/dmaas_top.sv */
/*
 DMA channel address select: Avalon-MM slave, five channels, request select.
 Assumes a 50 MHz MCLK and an Avalon master that holds requests until waitrequest is low.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmaas_regs.svh"
module dmaas_top
(
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic [1:0] AVS_RESPONSE,
   output logic [159:0] PERIPH_XFER_ADDR,
   output logic [159:0] MEM_XFER_ADDR,
   output logic [4:0] CHANNEL_ON,
   output logic [19:0] REQUEST_PICK
);
   localparam int NCH = `DMAAS_NUM_CHAN;
   dmaas_pkg::dmaas_req_s req;
   dmaas_pkg::dmaas_bus_e state_reg;
   dmaas_pkg::dmaas_bus_e state_next;
   logic [31:0] sel_reg;
   logic [31:0] be_mask;
   logic [31:0] rd_next;
   logic rd_hit;
   logic do_write;
   logic [NCH-1:0] cfg_we;
   logic [NCH-1:0] pb_we;
   logic [NCH-1:0] mb_we;
   logic [31:0] cfg_q [NCH];
   dmaas_pkg::dmaas_addr_s base_q [NCH];
   dmaas_pkg::dmaas_addr_s xfer_q [NCH];

   assign req.read = AVS_READ;
   assign req.write = AVS_WRITE;
   assign req.address = AVS_ADDRESS;
   assign req.byteenable = AVS_BYTEENABLE;
   assign req.writedata = AVS_WRITEDATA;
   assign be_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}}, {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
   // Write commits in the ACK state, the cycle waitrequest is low
   assign do_write = (state_reg == dmaas_pkg::DMAAS_ACK) && req.write;

   always_comb
   begin
      case (state_reg)
         dmaas_pkg::DMAAS_IDLE: state_next = (req.read || req.write) ? dmaas_pkg::DMAAS_ACK : dmaas_pkg::DMAAS_IDLE;
         dmaas_pkg::DMAAS_ACK: state_next = dmaas_pkg::DMAAS_DONE;
         dmaas_pkg::DMAAS_DONE: state_next = dmaas_pkg::DMAAS_IDLE;
         default: state_next = dmaas_pkg::DMAAS_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         state_reg <= dmaas_pkg::DMAAS_IDLE;
      else
         state_reg <= state_next;
   end

   // Waitrequest from a flop: low exactly in ACK
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         AVS_WAITREQUEST <= 1'b1;
      else
         AVS_WAITREQUEST <= !(state_next == dmaas_pkg::DMAAS_ACK);
   end

   always_comb
   begin
      cfg_we = '0;
      pb_we = '0;
      mb_we = '0;
      rd_next = 32'h0000_0000;
      rd_hit = 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
         if (req.address == 8'(`DMAAS_CFG_BASE + i * `DMAAS_CHAN_STRIDE))
         begin
            cfg_we[i] = do_write;
            rd_next = cfg_q[i];
            rd_hit = 1'b1;
         end
         if (req.address == 8'(`DMAAS_PB_BASE + i * `DMAAS_CHAN_STRIDE))
         begin
            pb_we[i] = do_write;
            rd_next = base_q[i].periph;
            rd_hit = 1'b1;
         end
         if (req.address == 8'(`DMAAS_MB_BASE + i * `DMAAS_CHAN_STRIDE))
         begin
            mb_we[i] = do_write;
            rd_next = base_q[i].mem;
            rd_hit = 1'b1;
         end
      end
      if (req.address == `DMAAS_SEL_OFF)
      begin
         rd_next = sel_reg;
         rd_hit = 1'b1;
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         sel_reg <= `DMAAS_RESET_VAL;
      // Reserved bits 31:20 never store
      else if (do_write && req.address == `DMAAS_SEL_OFF)
         sel_reg <= ((sel_reg & ~be_mask) | (req.writedata & be_mask)) & `DMAAS_SEL_MASK;
   end

   // Read data and response registered at the ACK edge
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         AVS_READDATA <= 32'h0000_0000;
      else if (state_next == dmaas_pkg::DMAAS_ACK)
         AVS_READDATA <= req.read ? rd_next : 32'h0000_0000;
   end

   // Unmapped address answers SLVERR, reads zero
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         AVS_RESPONSE <= 2'h0;
      else if (state_next == dmaas_pkg::DMAAS_ACK)
         AVS_RESPONSE <= rd_hit ? 2'h0 : 2'h2;
   end

   for (genvar g = 0; g < NCH; g++)
   begin : g_chan
      dmaas_chan u_chan
      (
         .clk(MCLK),
         .rst(SYS_RST),
         .cfg_we(cfg_we[g]),
         .pb_we(pb_we[g]),
         .mb_we(mb_we[g]),
         .wdata(req.writedata),
         .be(req.byteenable),
         .cfg_reg(cfg_q[g]),
         .base_reg(base_q[g]),
         .xfer_addr(xfer_q[g])
      );
   end

   // Outputs flopped: aligned addresses lag the registers by one cycle
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         PERIPH_XFER_ADDR <= '0;
         MEM_XFER_ADDR <= '0;
         CHANNEL_ON <= '0;
         REQUEST_PICK <= '0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            PERIPH_XFER_ADDR[32*i +: 32] <= xfer_q[i].periph;
            MEM_XFER_ADDR[32*i +: 32] <= xfer_q[i].mem;
            CHANNEL_ON[i] <= cfg_q[i][`DMAAS_ON_BIT];
         end
         REQUEST_PICK <= sel_reg[19:0];
      end
   end
endmodule // dmaas_top
`default_nettype wire

/* design/dmaas_regs.svh */
/*
 Register offsets, field positions, reset values and width codes for the DMA channel address select block.
 Assumes inclusion by bare name from design files only.
*/
`ifndef DMAAS_REGS_SVH
`define DMAAS_REGS_SVH
`define DMAAS_CFG_BASE 8'h08
`define DMAAS_PB_BASE 8'h10
`define DMAAS_MB_BASE 8'h14
`define DMAAS_CHAN_STRIDE 8'h14
`define DMAAS_SEL_OFF 8'ha8
`define DMAAS_NUM_CHAN 5
`define DMAAS_ON_BIT 0
`define DMAAS_PW_LSB 8
`define DMAAS_MW_LSB 10
`define DMAAS_CFG_MASK 32'h0000_7fff
`define DMAAS_SEL_MASK 32'h000f_ffff
`define DMAAS_RESET_VAL 32'h0000_0000
`define DMAAS_W8 2'h0
`define DMAAS_W16 2'h1
`define DMAAS_W32 2'h2
`endif

/* design/dmaas_pkg.sv */
/*
 Types shared by the DMA channel address select design.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dmaas_pkg;
   typedef struct packed
   {
      logic [31:0] periph;
      logic [31:0] mem;
   } dmaas_addr_s;
   typedef struct packed
   {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } dmaas_req_s;
   typedef enum logic [2:0]
   {
      DMAAS_IDLE = 3'b001,
      DMAAS_ACK = 3'b010,
      DMAAS_DONE = 3'b100
   } dmaas_bus_e;
endpackage

/* design/dmaas_align.sv */
/*
 Aligns one base address to the transfer width.
 Assumes width code and address are stable registers.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmaas_regs.svh"
module dmaas_align
(
   input wire logic [31:0] base,
   input wire logic [1:0] width,
   output logic [31:0] aligned
);
   always_comb
   begin
      case (width)
         `DMAAS_W16: aligned = {base[31:1], 1'b0};
         `DMAAS_W32: aligned = {base[31:2], 2'b00};
         // Reserved code treated as 8 bits: no masking
         default: aligned = base;
      endcase
   end
endmodule // dmaas_align
`default_nettype wire

/* design/dmaas_chan.sv */
/*
 One channel: configuration, peripheral and memory base registers with lock.
 Assumes write strobes are one-cycle pulses already decoded by the top.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmaas_regs.svh"
module dmaas_chan
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_we,
   input wire logic pb_we,
   input wire logic mb_we,
   input wire logic [31:0] wdata,
   input wire logic [3:0] be,
   output logic [31:0] cfg_reg,
   output dmaas_pkg::dmaas_addr_s base_reg,
   output dmaas_pkg::dmaas_addr_s xfer_addr
);
   logic [31:0] be_mask;
   logic channel_on;
   // Separate registers so each always_ff owns its whole variable
   logic [31:0] periph_reg;
   logic [31:0] mem_reg;
   assign base_reg = {periph_reg, mem_reg};
   assign be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   assign channel_on = cfg_reg[`DMAAS_ON_BIT];
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cfg_reg <= `DMAAS_RESET_VAL;
      else if (cfg_we)
         cfg_reg <= ((cfg_reg & ~be_mask) | (wdata & be_mask)) & `DMAAS_CFG_MASK;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         periph_reg <= `DMAAS_RESET_VAL;
      // Locked: write dropped silently, value kept
      else if (pb_we && !channel_on)
         periph_reg <= (periph_reg & ~be_mask) | (wdata & be_mask);
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mem_reg <= `DMAAS_RESET_VAL;
      else if (mb_we && !channel_on)
         mem_reg <= (mem_reg & ~be_mask) | (wdata & be_mask);
   end
   dmaas_align u_pal
   (
      .base(periph_reg),
      .width(cfg_reg[`DMAAS_PW_LSB +: 2]),
      .aligned(xfer_addr.periph)
   );
   dmaas_align u_mal
   (
      .base(mem_reg),
      .width(cfg_reg[`DMAAS_MW_LSB +: 2]),
      .aligned(xfer_addr.mem)
   );
endmodule // dmaas_chan
`default_nettype wire

/* test/dmaas_checker.sv */
/*
 Port assertions for the DMA channel address select block.
 Assumes binding onto dmaas_top, one clock, reset active high.
*/
`timescale 1ns/100ps
`default_nettype none
module dmaas_checker
(
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [1:0] AVS_RESPONSE,
   input wire logic [4:0] CHANNEL_ON,
   input wire logic [19:0] REQUEST_PICK
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   wire logic rd_ok = AVS_READ && !AVS_WAITREQUEST;
   wait_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   wait_cause_a: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
      else $error("answer without request");
   answer_lat_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
      else $error("answer late");
   unmapped_err_a: assert property (!AVS_WAITREQUEST && AVS_ADDRESS > 8'ha8 |-> AVS_RESPONSE == 2'h2)
      else $error("unmapped not refused");
   mapped_ok_a: assert property (!AVS_WAITREQUEST && AVS_ADDRESS inside {8'h10, 8'h14} |-> AVS_RESPONSE == 2'h0)
      else $error("mapped access refused");
   sel_resv_a: assert property (rd_ok && AVS_ADDRESS == 8'ha8 |-> AVS_READDATA[31:20] == 12'h0)
      else $error("select reserved bits set");
   pick_copy_a: assert property (rd_ok && AVS_ADDRESS == 8'ha8 |-> AVS_READDATA[19:0] == REQUEST_PICK)
      else $error("request pick differs");
   on_copy_a: assert property (rd_ok && AVS_ADDRESS == 8'h08 |-> AVS_READDATA[0] == CHANNEL_ON[0])
      else $error("channel on differs");
endmodule // dmaas_checker
bind dmaas_top dmaas_checker chk (.MCLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
   .AVS_WAITREQUEST, .AVS_RESPONSE, .CHANNEL_ON, .REQUEST_PICK);
`default_nettype wire

/* test/dmaas_mem_model.sv */
/*
 Memory bus model: one access per channel start, at its aligned addresses.
 Assumes transfer addresses settle within two edges of channel on.
*/
`timescale 1ns/100ps
`default_nettype none
module dmaas_mem_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] chan_on,
   input wire logic [159:0] periph,
   input wire logic [159:0] mem,
   output logic acc_v,
   output dmaas_pkg::dmaas_addr_s acc
);
   logic [4:0] on_q;
   logic [4:0] on_qq;
   // Extra stage lets the aligned addresses land first
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         on_q <= 5'h0;
         on_qq <= 5'h0;
         acc_v <= 1'b0;
         acc <= '0;
      end
      else
      begin
         on_q <= chan_on;
         on_qq <= on_q;
         acc_v <= 1'b0;
         for (int i = 0; i < 5; i++)
            if (on_q[i] && !on_qq[i])
            begin
               acc_v <= 1'b1;
               acc <= {periph[32*i +: 32], mem[32*i +: 32]};
            end
      end
endmodule // dmaas_mem_model
`default_nettype wire

/* test/dma_channel_address_select_bench.sv */
/*
 Self-checking bench: register reads and model accesses checked from queues.
 Assumes design, package, checker and model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_channel_address_select_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   wire logic [31:0] rdata;
   wire logic waitreq;
   wire logic [159:0] pxa;
   wire logic [159:0] mxa;
   wire logic [4:0] chon;
   logic acc_v;
   dmaas_pkg::dmaas_addr_s acc;
   logic [31:0] rq[$];
   logic [63:0] aq[$];
   int error_cnt = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h7b00;
   always #10 clk = ~clk;
   dmaas_top uut (.MCLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .AVS_RESPONSE(), .PERIPH_XFER_ADDR(pxa), .MEM_XFER_ADDR(mxa), .CHANNEL_ON(chon), .REQUEST_PICK());
   dmaas_mem_model mdl (.clk(clk), .rst(rst), .chan_on(chon), .periph(pxa), .mem(mxa), .acc_v(acc_v), .acc(acc));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] al(input logic [31:0] a, input logic [1:0] w);
      return w == 2'h1 ? {a[31:1], 1'b0} : w == 2'h2 ? {a[31:2], 2'h0} : a;
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      // Expected results never seen count against the run
      error_cnt += rq.size() + aq.size();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Holds the request until waitrequest is sampled low; only the watchdog ends a hang
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      do
      begin
         @(posedge clk);
      end
      while (waitreq !== 1'b0);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   always @(posedge clk)
   begin
      if (rd && waitreq === 1'b0)
         chk(rdata, rq.pop_front());
      if (acc_v === 1'b1)
         chk(acc, aq.pop_front());
   end
   initial
   begin
      logic [31:0] p;
      logic [31:0] m;
      logic [31:0] c;
      logic [7:0] pb;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         pb = 8'(8'h10 + 8'h14 * i);
         p = rnd();
         m = rnd();
         // Width codes walk all four values across the channels
         c = (rnd() & 32'hfffff0fe) | {20'h0, 2'(i + 1), 2'(i), 8'h01};
         rdc(pb, 32'h0);
         rdc(pb + 8'h4, 32'h0);
         bus(1'b1, pb, p);
         bus(1'b1, pb + 8'h4, m);
         rdc(pb, p);
         rdc(pb + 8'h4, m);
         aq.push_back({al(p, c[9:8]), al(m, c[11:10])});
         bus(1'b1, pb - 8'h8, c);
         rdc(pb - 8'h8, c & 32'h7fff);
         bus(1'b1, pb, ~p);
         bus(1'b1, pb + 8'h4, ~m);
         rdc(pb, p);
         rdc(pb + 8'h4, m);
         bus(1'b1, pb - 8'h8, 32'h0);
         bus(1'b1, pb, ~p);
         rdc(pb, ~p);
      end
      p = rnd();
      bus(1'b1, 8'ha8, p);
      rdc(8'ha8, p & 32'hfffff);
      bus(1'b1, 8'hfc, p);
      rdc(8'hfc, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(8'ha8, 32'h0);
      rdc(8'h10, 32'h0);
      // Let the checking process take the last read first
      repeat (4) @(posedge clk);
      stop_test;
   end
   // Whole run is well under ten thousand cycles
   initial
   begin
      #200000;
      error_cnt++;
      stop_test;
   end
endmodule // dma_channel_address_select_bench
`default_nettype wire
